// file: design/cycle_core_pkg.sv
// Constants for the instruction timing core
package cycle_core_pkg;
	localparam int          CLKS_PER_CYCLE  = 4;
	localparam logic [1:0]  PHASE_LAST      = 2'h3;
	localparam logic [15:0] PC_RESET        = 16'h0000;
	localparam logic [7:0]  ACC_RESET       = 8'h00;
	localparam logic [7:0]  PSW_RESET       = 8'h00;
	// Status bit positions
	localparam int          PSW_CY          = 7;
	localparam int          PSW_AC          = 6;
	localparam int          PSW_OV          = 2;
	// Opcodes
	localparam logic [7:0]  OP_NOP          = 8'h00;
	localparam logic [7:0]  OP_ADD_IMM      = 8'h24;
	localparam logic [7:0]  OP_ADD_DIR      = 8'h25;
	localparam logic [7:0]  OP_ADD_IND0     = 8'h26;
	localparam logic [7:0]  OP_ADD_WITH_CARRY_IMM     = 8'h34;
	localparam logic [7:0]  OP_ADD_WITH_CARRY_DIR     = 8'h35;
	localparam logic [7:0]  OP_LJMP         = 8'h02;
	localparam logic [4:0]  OP_AJMP_LOW     = 5'h01;
	localparam logic [7:0]  OP_CLR_C        = 8'hC3;
	localparam logic [7:0]  OP_SETB_C       = 8'hD3;
	localparam logic [7:0]  OP_CPL_C        = 8'hB3;
	localparam logic [7:0]  OP_RRC          = 8'h13;
	localparam logic [7:0]  OP_RLC          = 8'h33;
	localparam logic [7:0]  OP_SUBTRACT_WITH_BORROW_IMM     = 8'h94;
	typedef enum logic [1:0] {ST_FETCH, ST_OPERAND, ST_ADDR} state_e;
endpackage : cycle_core_pkg

// file: design/instruction_cycle_timing.sv
// Instruction execution and machine cycle timing core
//
// Operation
// - Instructions keep the classic operation and flag effects.
// - Each machine cycle lasts exactly four clock periods.
// - At most one code fetch is issued per machine cycle.
// - Non-jump cycle count equals byte count, one byte fetched per cycle.
// - Jumps take one extra cycle to form the new address.
// - Add group sets carry, overflow, aux carry; carry ops touch carry.
// - No-op and one-byte adds take 1 cycle; direct/immediate adds 2.
`timescale 1ns/100ps
module instruction_cycle_timing
	import cycle_core_pkg::*;
(
	input  wire logic        clock_in,
	input  wire logic        rstn_in,
	input  wire logic [7:0]  code_data_in,
	input  wire logic [7:0]  operand_data_in,
	output logic      [15:0] code_addr_out,
	output logic             code_fetch_out,
	output logic             cycle_start_out,
	output logic             instr_done_out,
	output logic      [7:0]  acc_out,
	output logic      [7:0]  psw_out
);

	// Add with carry-in, returns {cy, ac, ov, sum}
	function automatic logic [10:0] add8(input logic [7:0] a,
		input logic [7:0] b, input logic ci);
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] r;
		s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
		h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		r = s[7:0];
		add8 = {s[8], h[4], (a[7] == b[7]) && (r[7] != a[7]), r};
	endfunction : add8

	// Bytes in an instruction
	function automatic logic [1:0] op_bytes(input logic [7:0] op);
		if (op == OP_LJMP)
			op_bytes = 2'h3;
		else if (op == OP_ADD_IMM || op == OP_ADD_DIR
			|| op == OP_ADD_WITH_CARRY_IMM || op == OP_ADD_WITH_CARRY_DIR
			|| op == OP_SUBTRACT_WITH_BORROW_IMM || op[4:0] == OP_AJMP_LOW)
			op_bytes = 2'h2;
		else
			op_bytes = 2'h1;
	endfunction : op_bytes

	// Jump needs an address cycle
	function automatic logic is_jump(input logic [7:0] op);
		is_jump = (op == OP_LJMP) || (op[4:0] == OP_AJMP_LOW);
	endfunction : is_jump

	// Immediate forms read the code stream; register, indirect
	// and direct forms read the data side
	function automatic logic is_imm(input logic [7:0] op);
		is_imm = (op[3:0] == 4'h4);
	endfunction : is_imm

	// Sequencing state
	state_e      state_q, state_d;
	logic [1:0]  phase_q, phase_d;
	logic [15:0] pc_q, pc_d;
	logic [7:0]  op_q, op_d;
	logic [7:0]  hi_q, hi_d;
	logic [7:0]  lo_q, lo_d;
	logic [1:0]  left_q, left_d;
	// Architectural results
	logic [7:0]  acc_q, acc_d;
	logic [7:0]  psw_q, psw_d;
	// Registered strobes
	logic        fetch_q, fetch_d;
	logic        start_q, start_d;
	logic        done_q, done_d;
	// Decode scratch, set at the top of the next-state process
	logic [10:0] res;
	logic [7:0]  opnd;
	logic [7:0]  cur;
	logic        last;

	// Next-state: phase counter, fetch, execute
	// Memory gets four clocks to settle before the sample
	always_comb begin
		state_d = state_q;
		phase_d = phase_q + 2'h1;
		pc_d    = pc_q;
		op_d    = op_q;
		hi_d    = hi_q;
		lo_d    = lo_q;
		left_d  = left_q;
		acc_d   = acc_q;
		psw_d   = psw_q;
		fetch_d = 1'b0;
		start_d = (phase_q == PHASE_LAST);
		done_d  = 1'b0;
		res     = 11'h000;
		opnd    = 8'h00;
		cur     = (state_q == ST_FETCH) ? code_data_in : op_q;
		last    = 1'b0;
		if (phase_q == PHASE_LAST) begin
			// At most one fetch per machine cycle, only in the last phase
			case (state_q)
				// Opcode byte sets the length
				ST_FETCH: begin
					fetch_d = 1'b1;
					pc_d    = pc_q + 16'h0001;
					op_d    = code_data_in;
					left_d  = op_bytes(code_data_in) - 2'h1;
					if (op_bytes(code_data_in) != 2'h1)
						state_d = ST_OPERAND;
					else
						last = 1'b1;
				end
				// Operand bytes, one per machine cycle
				ST_OPERAND: begin
					fetch_d = 1'b1;
					pc_d    = pc_q + 16'h0001;
					// Long jump: high byte, then low
					if (left_q == 2'h1 && op_q == OP_LJMP)
						lo_d = code_data_in;
					else
						hi_d = code_data_in;
					left_d  = left_q - 2'h1;
					if (left_q != 2'h1)
						state_d = ST_OPERAND;
					else if (is_jump(op_q))
						state_d = ST_ADDR;
					else begin
						state_d = ST_FETCH;
						last    = 1'b1;
					end
				end
				ST_ADDR: begin
					// No fetch: new address formed
					if (op_q == OP_LJMP)
						pc_d = {hi_q, lo_q};
					else
						pc_d = {pc_q[15:11], op_q[7:5], hi_q};
					state_d = ST_FETCH;
					done_d  = 1'b1;
				end
				default: state_d = ST_FETCH;
			endcase
		end
		// Retire: results land with the done pulse
		if (last) begin
			done_d = 1'b1;
			// Immediate byte is on the code bus in this phase
			opnd = is_imm(cur) ? code_data_in : operand_data_in;
			case (cur)
				OP_CLR_C:  psw_d[PSW_CY] = 1'b0;
				OP_SETB_C: psw_d[PSW_CY] = 1'b1;
				OP_CPL_C:  psw_d[PSW_CY] = ~psw_q[PSW_CY];
				OP_RRC: begin
					acc_d = {psw_q[PSW_CY], acc_q[7:1]};
					psw_d[PSW_CY] = acc_q[0];
				end
				OP_RLC: begin
					acc_d = {acc_q[6:0], psw_q[PSW_CY]};
					psw_d[PSW_CY] = acc_q[7];
				end
				OP_SUBTRACT_WITH_BORROW_IMM: begin
					res = add8(acc_q, ~opnd, ~psw_q[PSW_CY]);
					acc_d = res[7:0];
					psw_d[PSW_CY] = ~res[10];
					psw_d[PSW_AC] = ~res[9];
					psw_d[PSW_OV] = res[8];
				end
				default: begin
					// Add and add_with_carry group
					if (cur[7:5] == 3'h1 && (cur[3] || cur[2:1] == 2'h3
						|| cur[2:1] == 2'h2)) begin
						res = add8(acc_q, opnd, cur[4] & psw_q[PSW_CY]);
						acc_d = res[7:0];
						psw_d[PSW_CY] = res[10];
						psw_d[PSW_AC] = res[9];
						psw_d[PSW_OV] = res[8];
					end
				end
			endcase
		end
	end

	// Register all state
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_q <= ST_FETCH;
			phase_q <= 2'h0;
			pc_q    <= PC_RESET;
			op_q    <= OP_NOP;
			hi_q    <= 8'h00;
			lo_q    <= 8'h00;
			left_q  <= 2'h0;
			acc_q   <= ACC_RESET;
			psw_q   <= PSW_RESET;
			fetch_q <= 1'b0;
			start_q <= 1'b0;
			done_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			phase_q <= phase_d;
			pc_q    <= pc_d;
			op_q    <= op_d;
			hi_q    <= hi_d;
			lo_q    <= lo_d;
			left_q  <= left_d;
			acc_q   <= acc_d;
			psw_q   <= psw_d;
			fetch_q <= fetch_d;
			start_q <= start_d;
			done_q  <= done_d;
		end
	end

	// Outputs straight from registers
	assign code_addr_out   = pc_q;
	assign code_fetch_out  = fetch_q;
	assign cycle_start_out = start_q;
	assign instr_done_out  = done_q;
	assign acc_out         = acc_q;
	assign psw_out         = psw_q;

endmodule : instruction_cycle_timing

// file: sim/cycle_core_sva.sv
// Port checker for the instruction timing core
`timescale 1ns/100ps
module cycle_core_sva
	import cycle_core_pkg::*;
(
	input wire logic        clock_in,
	input wire logic        rstn_in,
	input wire logic [15:0] code_addr_out,
	input wire logic        code_fetch_out,
	input wire logic        cycle_start_out,
	input wire logic        instr_done_out,
	input wire logic [7:0]  acc_out,
	input wire logic [7:0]  psw_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rstn_in);
	// Machine cycle, fetch and retire spacing
	property p_cyc; cycle_start_out |=>
		!cycle_start_out [*3] ##1 cycle_start_out; endproperty
	a_cyc: assert property (p_cyc) else $error("cycle len");
	property p_one; code_fetch_out |=> !code_fetch_out [*3]; endproperty
	a_one: assert property (p_one) else $error("fetch gap");
	property p_sync; code_fetch_out |-> cycle_start_out; endproperty
	a_sync: assert property (p_sync) else $error("fetch phase");
	property p_hold; !code_fetch_out && !instr_done_out |->
		$stable(code_addr_out); endproperty
	a_hold: assert property (p_hold) else $error("pc moved");
	property p_pc; code_fetch_out |->
		code_addr_out == $past(code_addr_out) + 16'h0001; endproperty
	a_pc: assert property (p_pc) else $error("pc step");
	property p_done; instr_done_out |=> !instr_done_out [*3]; endproperty
	a_done: assert property (p_done) else $error("retire gap");
	property p_jmp; instr_done_out && !code_fetch_out |->
		$past(code_fetch_out, 4); endproperty
	a_jmp: assert property (p_jmp) else $error("jump cycle");
	property p_src; instr_done_out |->
		code_fetch_out || $past(code_fetch_out, 4); endproperty
	a_src: assert property (p_src) else $error("retire cause");
	// Results move only when an instruction retires
	property p_psw; $changed(psw_out) |-> instr_done_out; endproperty
	a_psw: assert property (p_psw) else $error("psw moved");
	property p_acc; $changed(acc_out) |-> instr_done_out; endproperty
	a_acc: assert property (p_acc) else $error("acc moved");
endmodule : cycle_core_sva
bind instruction_cycle_timing cycle_core_sva cycle_core_sva_i (
	.clock_in(clock_in), .rstn_in(rstn_in), .code_addr_out(code_addr_out),
	.code_fetch_out(code_fetch_out), .cycle_start_out(cycle_start_out),
	.instr_done_out(instr_done_out), .acc_out(acc_out), .psw_out(psw_out));

// file: sim/code_rom_model.sv
// Program memory model feeding code bytes
`timescale 1ns/100ps
module code_rom_model (
	input  wire logic [15:0] addr_in,
	output logic      [7:0]  data_out
);
	// Adds, carry ops, short jump, data adds, rotates, long jump
	logic [7:0] mem [32] = '{
		8'h00, 8'h24, 8'h7F, 8'h24, 8'h01, 8'h28, 8'h34, 8'hFF,
		8'hC3, 8'hD3, 8'hB3, 8'h01, 8'h10, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h25, 8'h30, 8'h26, 8'h94, 8'h01, 8'h13, 8'h33,
		8'h02, 8'h00, 8'h1C, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
	assign data_out = mem[addr_in[4:0]];
endmodule : code_rom_model

// file: sim/instruction_cycle_timing_test.sv
// Self-checking bench for the instruction timing core
`timescale 1ns/100ps
module instruction_cycle_timing_test;
	logic        clock_in = 1'b0;
	logic        rstn_in = 1'b0;
	logic [7:0]  code_data_in;
	logic [7:0]  operand_data_in = 8'h00;
	logic [15:0] code_addr_out;
	logic        code_fetch_out, cycle_start_out, instr_done_out;
	logic [7:0]  acc_out, psw_out;
	logic [2:0]  strobes;
	int          miscompares = 0;
	int          checks = 0;
	int          n;
	// Operand, acc, status, pc low byte, clocks
	logic [39:0] rows [17] = '{40'h00_00_00_01_04, 40'h00_7F_00_03_08,
		40'h00_80_44_05_08, 40'h80_00_84_06_04, 40'h00_00_C0_08_08,
		40'h00_00_40_09_04, 40'h00_00_C0_0A_04, 40'h00_00_40_0B_04,
		40'h00_00_40_10_0C, 40'h00_00_40_11_04, 40'h15_15_00_13_08,
		40'hEB_00_C0_14_04, 40'h00_FE_C0_16_08, 40'h00_FF_40_17_04,
		40'h00_FE_C0_18_04, 40'h00_FE_C0_1C_10, 40'h00_FE_C0_1D_04};
	assign strobes = {code_fetch_out, cycle_start_out, instr_done_out};
	instruction_cycle_timing instruction_cycle_timing_i (.clock_in(clock_in),
		.rstn_in(rstn_in), .code_data_in(code_data_in),
		.operand_data_in(operand_data_in), .code_addr_out(code_addr_out),
		.code_fetch_out(code_fetch_out), .cycle_start_out(cycle_start_out),
		.instr_done_out(instr_done_out), .acc_out(acc_out), .psw_out(psw_out));
	code_rom_model code_rom_model_i (.addr_in(code_addr_out),
		.data_out(code_data_in));
	task automatic check(input logic [15:0] got, exp, input string what);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t %s", $time, what);
		end
	endtask : check
	task automatic end_of_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test
	always #25 clock_in = ~clock_in;
	// Reset state, program rows, then mid-run reset and restart
	initial begin
		repeat (12) @(posedge clock_in);
		check({acc_out, psw_out}, 16'h0000, "reset state");
		check(code_addr_out, 16'h0000, "reset pc");
		check(16'(strobes), 16'h0000, "reset strobes");
		$display("power-up reset test ended");
		rstn_in <= 1'b1;
		for (int i = 0; i < 17; i++) begin
			n = 0;
			do begin
				@(posedge clock_in);
				operand_data_in <= rows[i][39:32];
				#1 n++;
			end while (instr_done_out !== 1'b1 && n < 20);
			check(16'(n), {8'h00, rows[i][7:0]}, "clocks");
			check(code_addr_out, {8'h00, rows[i][15:8]}, "pc");
			check({acc_out, psw_out}, rows[i][31:16], "result");
			$display("row %0d ended", i);
		end
		check(code_addr_out, 16'h001D, "jump target");
		@(posedge clock_in);
		rstn_in <= 1'b0;
		#1 check({acc_out, psw_out}, 16'h0000, "mid reset");
		check(code_addr_out, 16'h0000, "mid reset pc");
		repeat (3) @(posedge clock_in);
		rstn_in <= 1'b1;
		n = 0;
		do begin
			@(posedge clock_in);
			#1 n++;
		end while (instr_done_out !== 1'b1 && n < 20);
		check(16'(n), 16'h0004, "restart clocks");
		check(code_addr_out, 16'h0001, "restart pc");
		$display("reset test ended");
		end_of_test();
	end
	// Watchdog
	initial begin
		#20000;
		miscompares++;
		end_of_test();
	end
endmodule : instruction_cycle_timing_test
